// *** afn_codec_model.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Codec clocked from the master-clock pad
// ****************************************************************
module afn_codec_model (
  input wire logic pad_o,
  input wire logic pad_oe,
  output logic pad_line,
  output logic [15:0] n_edge
);
  // Released pad shows the inverse level
  always_comb begin
    pad_line = pad_oe ? pad_o : ~pad_o;
  end

  initial begin
    n_edge = 16'h0000;
  end

  // Counts clock edges only while driven
  always @(posedge pad_line) begin
    if (pad_oe) begin
      n_edge <= n_edge + 16'h0001;
    end
  end
endmodule

// *** afn_nco.sv ***
`timescale 1ns/100ps
module afn_nco (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [afn_pkg::INC_W-1:0] incr,
  output logic phase_msb
);

  typedef struct packed {
    logic [afn_pkg::ACC_W-1:0] acc;
  } afn_nco_state_t;

  afn_nco_state_t st_reg;
  afn_nco_state_t st_next;

  // Accumulate increment every cycle
  always_comb begin
    st_next = st_reg;
    st_next.acc = st_reg.acc + {1'b0, incr};
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase_msb = st_reg.acc[afn_pkg::ACC_W-1];

  property p_acc_step;
    @(posedge sys_clk) disable iff (!arst_n)
      st_reg.acc == $past(st_reg.acc) + {1'b0, $past(incr)};
  endproperty
  a_acc_step: assert property (p_acc_step)
    else $error("accumulator did not add increment");

endmodule

// *** afn_pkg.sv ***
package afn_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] FIFO_STATUS_OFF = 8'h30;
  localparam logic [7:0] FIFO_THRESHOLD_CONFIG_OFF = 8'h34;
  localparam logic [7:0] MASTER_CLOCK_SYNTH_CONFIG_OFF = 8'h38;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h40;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h44;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h48;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int RX_THR_LSB = 8;
  localparam int TX_THR_LSB = 0;
  localparam int SYNTH_EN_BIT = 31;
  localparam int INC_W = 20;
  localparam int ACC_W = 21;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam logic [7:0] RX_THR_RST = 8'h00;
  localparam logic [7:0] TX_THR_RST = 8'h40;
  localparam logic [7:0] TX_FREE_RST = 8'hFF;
  localparam logic [31:0] SYNTH_RST = 32'h0000_0000;

  // ****************************************************************
  // Carried groups
  // ****************************************************************
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } afn_aphase_t;

  typedef struct packed {
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
  } afn_fifo_ev_t;

endpackage

// *** afn_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Receive flag when rx bytes reach threshold
// - Transmit flag at threshold, reset 0x40
// - Enable bit selects oscillator as clock
// - Enable bit also drives master-clock pad
// - Readable receive FIFO byte count
// - Readable transmit FIFO free count
module afn_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic alt_mclk,
  output logic mclk_out,
  output logic mclk_pad_o,
  output logic mclk_pad_oe,
  output logic irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    afn_pkg::afn_aphase_t ap;
    logic [7:0] rx_thr;
    logic [7:0] tx_thr;
    logic synth_en;
    logic [afn_pkg::INC_W-1:0] incr;
    logic [7:0] rx_cnt;
    logic [7:0] tx_free;
    logic rx_lvl_d;
    logic tx_lvl_d;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] rdata;
    logic mclk;
    logic pad_o;
    logic pad_oe;
    logic irq;
  } afn_state_t;

  afn_state_t st_reg;
  afn_state_t st_next;
  afn_pkg::afn_fifo_ev_t ev;
  logic nco_msb;
  logic rx_lvl;
  logic tx_lvl;
  logic [1:0] irq_set;
  logic [7:0] tx_used;

  function automatic logic [7:0] cnt_step(input logic [7:0] c,
                                          input logic up,
                                          input logic dn);
    logic [7:0] r;
    r = c;
    if (up && !dn && c != 8'hFF) begin
      r = c + 8'h01;
    end else if (dn && !up && c != 8'h00) begin
      r = c - 8'h01;
    end
    return r;
  endfunction

  afn_nco u_nco (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .incr(st_reg.incr),
    .phase_msb(nco_msb)
  );

  assign ev = '{rx_push: rx_push, rx_pop: rx_pop,
                tx_push: tx_push, tx_pop: tx_pop};
  assign tx_used = 8'hFF - st_reg.tx_free;
  assign rx_lvl = st_reg.rx_cnt >= st_reg.rx_thr;
  assign tx_lvl = tx_used >= st_reg.tx_thr;
  assign irq_set[afn_pkg::IRQ_RX_BIT] = rx_lvl && !st_reg.rx_lvl_d;
  assign irq_set[afn_pkg::IRQ_TX_BIT] = tx_lvl && !st_reg.tx_lvl_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] rd;
    logic [1:0] clr;
    rd = 32'h0000_0000;
    clr = 2'b00;
    st_next = st_reg;
    // Byte counters
    st_next.rx_cnt = cnt_step(st_reg.rx_cnt, ev.rx_push,
                              ev.rx_pop);
    st_next.tx_free = cnt_step(st_reg.tx_free, ev.tx_pop,
                               ev.tx_push);
    st_next.rx_lvl_d = rx_lvl;
    st_next.tx_lvl_d = tx_lvl;
    // Write data phase
    if (st_reg.ap.sel && st_reg.ap.write) begin
      case (st_reg.ap.addr)
        afn_pkg::FIFO_THRESHOLD_CONFIG_OFF: begin
          st_next.rx_thr = hwdata[afn_pkg::RX_THR_LSB +: 8];
          st_next.tx_thr = hwdata[afn_pkg::TX_THR_LSB +: 8];
        end
        afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF: begin
          st_next.synth_en = hwdata[afn_pkg::SYNTH_EN_BIT];
          st_next.incr = hwdata[afn_pkg::INC_W-1:0];
        end
        afn_pkg::IRQ_ENABLE_OFF: begin
          st_next.irq_en = hwdata[1:0];
        end
        afn_pkg::IRQ_CLEAR_OFF: begin
          clr = hwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over clear
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | irq_set;
    // Address phase
    st_next.ap.sel = hsel && hready && htrans[1];
    st_next.ap.write = hwrite;
    st_next.ap.addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        afn_pkg::FIFO_STATUS_OFF: begin
          rd = {16'h0000, st_reg.rx_cnt, st_reg.tx_free};
        end
        afn_pkg::FIFO_THRESHOLD_CONFIG_OFF: begin
          rd = {16'h0000, st_reg.rx_thr, st_reg.tx_thr};
        end
        afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF: begin
          rd = {st_reg.synth_en, 11'h000, st_reg.incr};
        end
        afn_pkg::IRQ_STATUS_OFF: begin
          rd = {30'h0000_0000, st_reg.irq_stat};
        end
        afn_pkg::IRQ_ENABLE_OFF: begin
          rd = {30'h0000_0000, st_reg.irq_en};
        end
        default: begin
          rd = 32'h0000_0000;
        end
      endcase
    end
    st_next.rdata = rd;
    // Clock source and pad
    st_next.mclk = st_reg.synth_en ? nco_msb : alt_mclk;
    st_next.pad_o = st_reg.synth_en ? nco_msb : 1'b0;
    st_next.pad_oe = st_reg.synth_en;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.rx_thr <= afn_pkg::RX_THR_RST;
      st_reg.tx_thr <= afn_pkg::TX_THR_RST;
      st_reg.tx_free <= afn_pkg::TX_FREE_RST;
      st_reg.synth_en <= afn_pkg::SYNTH_RST[afn_pkg::SYNTH_EN_BIT];
      st_reg.incr <= afn_pkg::SYNTH_RST[afn_pkg::INC_W-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mclk_out = st_reg.mclk;
  assign mclk_pad_o = st_reg.pad_o;
  assign mclk_pad_oe = st_reg.pad_oe;
  assign irq = st_reg.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rx_flag;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_reg.rx_cnt >= st_reg.rx_thr) && !st_reg.rx_lvl_d
      |=> st_reg.irq_stat[afn_pkg::IRQ_RX_BIT];
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("rx level flag not set");

  property p_tx_flag;
    @(posedge sys_clk) disable iff (!arst_n)
      (tx_used >= st_reg.tx_thr) && !st_reg.tx_lvl_d
      |=> st_reg.irq_stat[afn_pkg::IRQ_TX_BIT];
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("tx level flag not set");

  property p_src;
    @(posedge sys_clk) disable iff (!arst_n)
      st_reg.synth_en |=> mclk_out == $past(nco_msb);
  endproperty
  a_src: assert property (p_src)
    else $error("master clock not from oscillator");

  property p_pad;
    @(posedge sys_clk) disable iff (!arst_n)
      !st_reg.synth_en |=> !mclk_pad_oe && !mclk_pad_o;
  endproperty
  a_pad: assert property (p_pad)
    else $error("pad driven while synth disabled");

  property p_rx_cnt;
    @(posedge sys_clk) disable iff (!arst_n)
      rx_push && !rx_pop && st_reg.rx_cnt != 8'hFF
      |=> st_reg.rx_cnt == $past(st_reg.rx_cnt) + 8'h01;
  endproperty
  a_rx_cnt: assert property (p_rx_cnt)
    else $error("rx count did not increment");

  property p_tx_free;
    @(posedge sys_clk) disable iff (!arst_n)
      tx_push && !tx_pop && st_reg.tx_free != 8'h00
      |=> st_reg.tx_free == $past(st_reg.tx_free) - 8'h01;
  endproperty
  a_tx_free: assert property (p_tx_free)
    else $error("tx free count did not decrement");

  property p_incr_wr;
    @(posedge sys_clk) disable iff (!arst_n)
      st_reg.ap.sel && st_reg.ap.write &&
      st_reg.ap.addr == afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF
      |=> st_reg.incr == $past(hwdata[19:0]);
  endproperty
  a_incr_wr: assert property (p_incr_wr)
    else $error("increment write lost");

  property p_irq;
    @(posedge sys_clk) disable iff (!arst_n)
      ##1 irq == |($past(st_next.irq_stat) & $past(st_next.irq_en));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq output mismatch");

endmodule

// *** afn_top_tb.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Register-level bench
// ****************************************************************
module afn_top_tb;
  logic sys_clk, arst_n, hsel, hwrite, alt_mclk;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, mclk_out, mclk_pad_o, mclk_pad_oe, irq;
  logic pad_line;
  logic [15:0] n_edge, e0;
  afn_pkg::afn_fifo_ev_t ev;
  int n_mismatch, tests_run;
  int n_mc;
  logic mc_prev;
  // 12.5 MHz master clock from 100 MHz
  localparam logic [19:0] INCR = 20'h40000;

  afn_top DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_push(ev.rx_push), .rx_pop(ev.rx_pop),
    .tx_push(ev.tx_push), .tx_pop(ev.tx_pop), .alt_mclk(alt_mclk),
    .mclk_out(mclk_out), .mclk_pad_o(mclk_pad_o),
    .mclk_pad_oe(mclk_pad_oe), .irq(irq)
  );

  afn_codec_model codec (
    .pad_o(mclk_pad_o), .pad_oe(mclk_pad_oe), .pad_line(pad_line),
    .n_edge(n_edge)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 16);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask

  task automatic fifo(input afn_pkg::afn_fifo_ev_t e, input int n);
    repeat (n) begin
      ev <= e;
      @(posedge sys_clk);
    end
    ev <= '0;
    @(posedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    ev = '0;
    alt_mclk = 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdchk(afn_pkg::FIFO_STATUS_OFF, 32'h000000FF);
    chk(hresp, 32'h0);
    chk(hreadyout, 32'h1);
    rdchk(afn_pkg::FIFO_THRESHOLD_CONFIG_OFF, 32'h00000040);
    rdchk(afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF, 32'h0);
    rdchk(8'h3C, 32'h00000000);
    chk(mclk_pad_oe, 32'h0);
    wr(afn_pkg::IRQ_CLEAR_OFF, 32'h00000003);
    rdchk(afn_pkg::IRQ_STATUS_OFF, 32'h00000000);
    // Receive level one byte short, then reached
    wr(afn_pkg::FIFO_THRESHOLD_CONFIG_OFF, 32'h00000403);
    fifo(4'b1000, 3);
    rdchk(afn_pkg::FIFO_STATUS_OFF, 32'h000003FF);
    rdchk(afn_pkg::IRQ_STATUS_OFF, 32'h00000000);
    wr(afn_pkg::IRQ_ENABLE_OFF, 32'h00000003);
    fifo(4'b1000, 1);
    rdchk(afn_pkg::IRQ_STATUS_OFF, 32'h00000001);
    chk(irq, 32'h1);
    wr(afn_pkg::IRQ_ENABLE_OFF, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h0);
    wr(afn_pkg::IRQ_CLEAR_OFF, 32'h00000001);
    // Transmit level reached at three bytes
    fifo(4'b0010, 3);
    rdchk(afn_pkg::FIFO_STATUS_OFF, 32'h000004FC);
    rdchk(afn_pkg::IRQ_STATUS_OFF, 32'h00000002);
    chk(irq, 32'h1);
    wr(afn_pkg::IRQ_CLEAR_OFF, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h0);
    // Pop one byte from each side, both levels drop
    fifo(4'b0101, 1);
    rdchk(afn_pkg::FIFO_STATUS_OFF, 32'h000003FD);
    rdchk(afn_pkg::IRQ_STATUS_OFF, 32'h00000000);
    // Alternative source while synthesiser is off
    alt_mclk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(mclk_out, 32'h1);
    alt_mclk <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(mclk_out, 32'h0);
    wr(afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF, {1'b1, 11'h000, INCR});
    rdchk(afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF, 32'h80040000);
    repeat (4) @(posedge sys_clk);
    chk(mclk_pad_oe, 32'h1);
    // Ten master-clock periods in eighty system cycles
    e0 = n_edge;
    n_mc = 0;
    mc_prev = mclk_out;
    repeat (80) begin
      @(posedge sys_clk);
      if (mclk_out && !mc_prev) begin
        n_mc++;
      end
      mc_prev = mclk_out;
    end
    chk(n_edge - e0, 32'd10);
    chk(n_mc, 32'd10);
    wr(afn_pkg::MASTER_CLOCK_SYNTH_CONFIG_OFF, 32'h00000000);
    repeat (2) @(posedge sys_clk);
    chk(mclk_pad_oe, 32'h0);
    report_and_stop();
  end
endmodule
